// ===== hdl/mir_responder.sv
// manufacturer info responder and security block pass-through
// assumes the protocol layer delivers and accepts data blocks a byte at a time
// and that local firmware loads the strings before the first request
//
// Notes on behaviour
// - target zero is port, one battery
// - battery reference is index zero to seven
// - every info request gets an info reply
// - reply bytes zero, one carry vendor code
// - reply bytes two, three carry product code
// - vendor string follows from byte four
// - reply never exceeds legacy extended length
// - unrecognised target or reference gives empty string
// - security request block passes through unchanged
// - security response block also passes through unchanged to local policy
`timescale 1ns/1ps

module mir_responder (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // received data block
  input  wire logic                rx_valid,
  input  wire mir_pkg::mir_msg_e   rx_kind,
  input  wire mir_pkg::mir_beat_s  rx_beat,
  output logic                     rx_ready,
  // transmitted data block
  output logic                     tx_valid,
  output mir_pkg::mir_msg_e        tx_kind,
  output mir_pkg::mir_beat_s       tx_beat,
  output logic [8:0]               tx_size,
  input  wire logic                tx_ready,
  // local identity, index 8 is the port itself, 0..7 the batteries
  input  wire logic [15:0]         id_vendor [mir_pkg::MIR_NUM_SRC],
  input  wire logic [15:0]         id_product [mir_pkg::MIR_NUM_SRC],
  input  wire logic [8:0]          str_len [mir_pkg::MIR_NUM_SRC],
  input  wire logic [8:0]          batt_present,
  // string write port, loaded by local firmware
  input  wire logic                str_we,
  input  wire logic [3:0]          str_src,
  input  wire logic [4:0]          str_addr,
  input  wire logic [7:0]          str_wdata,
  // security blocks to local policy, with its ready back
  output logic                     sec_valid,
  output mir_pkg::mir_msg_e        sec_kind,
  output mir_pkg::mir_beat_s       sec_beat,
  input  wire logic                sec_ready,
  // status
  output logic                     bad_request,
  output logic                     busy
);

  ////////////////////////////////////////////////////////////////////////////
  // storage and state
  logic [7:0]              str_mem [mir_pkg::MIR_NUM_SRC][mir_pkg::MIR_STR_DEPTH];
  mir_pkg::mir_state_e     state;
  mir_pkg::mir_state_e     next_state;
  logic [7:0]              req_target;
  logic [7:0]              req_ref;
  logic [8:0]              req_count;
  logic [8:0]              byte_idx;
  logic [8:0]              reply_size;
  logic [3:0]              reply_src;

  // clamp a string length to what fits the legacy block
  // longer strings are cut short, never wrapped
  function automatic logic [8:0] clamp_len(input logic [8:0] len);
    clamp_len = (len > mir_pkg::MIR_STR_MAX) ? mir_pkg::MIR_STR_MAX : len;
  endfunction

  // one reply byte by position: vendor and product low byte first, then string
  function automatic logic [7:0] pick_byte(input logic [8:0]  idx,
                                           input logic [15:0] vendor,
                                           input logic [15:0] product,
                                           input logic [7:0]  sbyte);
    case (idx)
      9'h000:  pick_byte = vendor[7:0];
      9'h001:  pick_byte = vendor[15:8];
      9'h002:  pick_byte = product[7:0];
      9'h003:  pick_byte = product[15:8];
      default: pick_byte = sbyte;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // request decode
  // target decode
  wire        tgt_port  = (req_target == mir_pkg::MIR_TARGET_PORT);
  wire        tgt_batt  = (req_target == mir_pkg::MIR_TARGET_BATT);
  wire        ref_batt  = tgt_batt && (req_ref <= mir_pkg::MIR_BATT_MAX);
  wire        ref_port  = tgt_port && (req_ref == 8'h00);
  // request must be exactly one data byte pair
  wire        size_ok   = (req_count == mir_pkg::MIR_REQ_SIZE + 9'h001);
  // source of the ids: a battery index picks its own slot even when the
  // battery is absent, anything else falls back to the port itself
  wire [3:0]  dec_src   = ref_batt ? req_ref[3:0] : mir_pkg::MIR_SRC_PORT;
  // good only with exactly two bytes and a live target
  wire        dec_ok    = size_ok && (ref_port || (ref_batt && batt_present[dec_src]));
  wire [8:0]  dec_slen  = dec_ok ? clamp_len(str_len[dec_src]) : 9'h000;
  // clamping keeps the whole block inside the legacy limit
  // size is ids plus clamped string
  wire [8:0]  dec_size  = mir_pkg::MIR_ID_BYTES + dec_slen;

  // message kinds that open an exchange from idle
  wire        rx_get    = rx_valid && (rx_kind == mir_pkg::MIR_MSG_GET_INFO);
  wire        rx_sec    = rx_valid && (rx_kind == mir_pkg::MIR_MSG_SEC_REQ ||
                                       rx_kind == mir_pkg::MIR_MSG_SEC_RSP);
  // transfer strobes on both sides
  wire        rx_take   = rx_valid && rx_ready;
  wire        tx_take   = tx_valid && tx_ready;
  wire        last_byte = (byte_idx + 9'h001 == reply_size);

  ////////////////////////////////////////////////////////////////////////////
  // reply byte selection
  // the byte after the current one, fetched ahead so ready never waits
  wire [8:0]  nidx         = byte_idx + 9'h001;
  wire [4:0]  nstr_off     = 5'(nidx - mir_pkg::MIR_ID_BYTES);
  // past the end of the string memory the fetch reads zero, not a word out of range
  wire [7:0]  next_str     = (nstr_off < 5'(mir_pkg::MIR_STR_DEPTH)) ? str_mem[reply_src][nstr_off] : 8'h00;
  wire [7:0]  first_byte   = pick_byte(9'h000, id_vendor[dec_src], id_product[dec_src], 8'h00);
  wire [7:0]  next_tx_byte = pick_byte(nidx, id_vendor[reply_src], id_product[reply_src], next_str);
  wire        next_is_last = (nidx + 9'h001 == reply_size);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_state = state;
    case (state)
      // the opening byte is only looked at here, it is taken in the next state
      mir_pkg::MIR_ST_IDLE: begin
        if (rx_get) begin
          next_state = mir_pkg::MIR_ST_REQ;
        end else if (rx_sec) begin
          next_state = mir_pkg::MIR_ST_PASS;
        end
      end
      mir_pkg::MIR_ST_REQ: begin
        if (rx_take && rx_beat.last) begin
          next_state = mir_pkg::MIR_ST_HDR;
        end
      end
      mir_pkg::MIR_ST_HDR: next_state = mir_pkg::MIR_ST_SEND;
      // the last byte leaves only once the far side has taken it
      mir_pkg::MIR_ST_SEND: begin
        if (tx_take && last_byte) begin
          next_state = mir_pkg::MIR_ST_IDLE;
        end
      end
      // a security block ends on its last beat taken
      mir_pkg::MIR_ST_PASS: begin
        if (rx_take && rx_beat.last) begin
          next_state = mir_pkg::MIR_ST_IDLE;
        end
      end
      default: next_state = mir_pkg::MIR_ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= mir_pkg::MIR_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request capture
  // idle parks the fields on a reserved target, so a cut request
  // can never decode with the target of the one before it
  wire        cap_clear  = (state == mir_pkg::MIR_ST_IDLE);
  wire        cap_byte   = (state == mir_pkg::MIR_ST_REQ) && rx_take;
  wire        cap_target = cap_byte && (req_count == 9'h000);
  wire        cap_ref    = cap_byte && (req_count == 9'h001);
  // the count stops at its top so an endless request cannot wrap to two
  wire        cap_count  = cap_byte && (req_count != 9'h1FF);

  // target byte
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      req_target <= 8'h00;
    end else if (cap_clear) begin
      req_target <= 8'hFF;
    end else if (cap_target) begin
      req_target <= rx_beat.data;
    end
  end

  // reference byte
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      req_ref <= 8'h00;
    end else if (cap_clear) begin
      req_ref <= 8'hFF;
    end else if (cap_ref) begin
      req_ref <= rx_beat.data;
    end
  end

  // request byte count
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      req_count <= 9'h000;
    end else if (cap_clear) begin
      req_count <= 9'h000;
    end else if (cap_count) begin
      req_count <= req_count + 9'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reply latch and byte walk
  // the decode is frozen in the header cycle, so the reply size and source
  // cannot change under the far side while it is being sent
  wire        rep_load  = (state == mir_pkg::MIR_ST_HDR);
  wire        rep_step  = (state == mir_pkg::MIR_ST_SEND) && tx_take;

  // size, source and refusal flag of the reply in flight
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reply_size  <= mir_pkg::MIR_ID_BYTES;
      reply_src   <= mir_pkg::MIR_SRC_PORT;
      bad_request <= 1'b0;
    end else if (rep_load) begin
      reply_size  <= dec_size;
      reply_src   <= dec_src;
      bad_request <= !dec_ok;
    end
  end

  // position of the byte now offered
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      byte_idx <= 9'h000;
    end else if (rep_load) begin
      byte_idx <= 9'h000;
    end else if (rep_step) begin
      byte_idx <= byte_idx + 9'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit data from flip-flops
  // a reply is at least four bytes, so the first byte is never the last
  // the beat is rebuilt whole, so first and last can never be stale
  wire                tx_load      = rep_load || rep_step;
  mir_pkg::mir_beat_s next_tx_beat;
  assign next_tx_beat = '{data:  rep_load ? first_byte : next_tx_byte,
                          first: rep_load,
                          last:  rep_load ? 1'b0 : next_is_last};

  // transmit beat register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_beat <= '0;
    end else if (tx_load) begin
      tx_beat <= next_tx_beat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // string memory write, no reset: firmware fills it before use
  // out of range writes are dropped rather than landing in a neighbour
  // a write during a reply shows up in the bytes not yet fetched
  always_ff @(posedge sys_clk) begin
    if (str_we && str_src < 4'(mir_pkg::MIR_NUM_SRC) && str_addr < 5'(mir_pkg::MIR_STR_DEPTH)) begin
      str_mem[str_src][str_addr] <= str_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // handshakes and pass-through
  // receive side: bytes taken only while a message is open,
  // so idle, header and send refuse anything new
  assign rx_ready  = (state == mir_pkg::MIR_ST_REQ) ||
                     (state == mir_pkg::MIR_ST_PASS && sec_ready);

  // security blocks passed unchanged
  // no copy is kept: the local side's ready stalls the sender directly
  assign sec_valid = (state == mir_pkg::MIR_ST_PASS) && rx_valid;
  assign sec_kind  = rx_kind;
  assign sec_beat  = rx_beat;

  // reply side: kind and size stand for the whole reply
  // the size is latched, so it cannot move while bytes are stalled
  assign tx_valid  = (state == mir_pkg::MIR_ST_SEND);
  assign tx_kind   = mir_pkg::MIR_MSG_INFO;
  assign tx_size   = reply_size;

  // status
  assign busy      = (state != mir_pkg::MIR_ST_IDLE);

endmodule

// ===== hdl/mir_pkg.sv
// package for the manufacturer info responder
// assumes a byte-serial message layer on one 25 MHz clock
package mir_pkg;
  // message kinds seen and produced by the responder
  typedef enum logic [2:0] {
    MIR_MSG_NONE     = 3'b000,
    MIR_MSG_GET_INFO = 3'b001,
    MIR_MSG_INFO     = 3'b010,
    MIR_MSG_SEC_REQ  = 3'b011,
    MIR_MSG_SEC_RSP  = 3'b100
  } mir_msg_e;

  // responder states
  typedef enum logic [2:0] {
    MIR_ST_IDLE  = 3'b000,
    MIR_ST_REQ   = 3'b001,
    MIR_ST_HDR   = 3'b010,
    MIR_ST_SEND  = 3'b011,
    MIR_ST_PASS  = 3'b100
  } mir_state_e;

  // one byte of a data block with framing
  typedef struct packed {
    logic [7:0] data;
    logic       first;
    logic       last;
  } mir_beat_s;

  localparam logic [7:0] MIR_TARGET_PORT   = 8'h00;
  localparam logic [7:0] MIR_TARGET_BATT   = 8'h01;
  localparam logic [7:0] MIR_BATT_MAX      = 8'h07;
  localparam logic [8:0] MIR_REQ_SIZE      = 9'h001;
  localparam logic [8:0] MIR_ID_BYTES      = 9'h004;
  localparam logic [8:0] MIR_LEGACY_MAX    = 9'h01A;
  localparam logic [8:0] MIR_STR_MAX       = 9'h016;
  localparam int         MIR_STR_DEPTH     = 22;
  localparam int         MIR_NUM_SRC       = 9;
  localparam logic [3:0] MIR_SRC_PORT      = 4'h8;
  localparam logic [8:0] MIR_SEC_MAX       = 9'h104;
endpackage

// ===== verif/mir_peer.sv
// far-side port partner model: takes reply bytes
// assumes one clock, inputs moved at the falling edge
`timescale 1ns/1ps

module mir_peer (
  input  wire logic sys_clk,
  input  wire logic slow,
  output logic      tx_ready
);
  initial tx_ready = 1'b0;
  always @(negedge sys_clk) tx_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
endmodule

// ===== verif/mir_responder_sva.sv
// port assertions for the responder
// assumes bind onto mir_responder, one clock domain
`timescale 1ns/1ps

module mir_responder_sva (
  input wire logic               sys_clk,
  input wire logic               rst,
  input wire logic               rx_valid,
  input wire mir_pkg::mir_msg_e  rx_kind,
  input wire mir_pkg::mir_beat_s rx_beat,
  input wire logic               rx_ready,
  input wire logic               tx_valid,
  input wire mir_pkg::mir_msg_e  tx_kind,
  input wire mir_pkg::mir_beat_s tx_beat,
  input wire logic [8:0]         tx_size,
  input wire logic               tx_ready,
  input wire logic               sec_valid,
  input wire mir_pkg::mir_msg_e  sec_kind,
  input wire mir_pkg::mir_beat_s sec_beat,
  input wire logic               sec_ready,
  input wire logic               bad_request,
  input wire logic               busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  // reply shape and timing
  property p_kind; tx_valid |-> tx_kind == mir_pkg::MIR_MSG_INFO; endproperty
  property p_ans; rx_valid && rx_ready && rx_beat.last && rx_kind == mir_pkg::MIR_MSG_GET_INFO
    |=> !tx_valid ##1 tx_valid; endproperty
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_beat) && $stable(tx_size); endproperty
  property p_first; $rose(tx_valid) |-> tx_beat.first; endproperty
  property p_end; tx_valid && tx_ready && tx_beat.last |=> !tx_valid; endproperty
  property p_size; tx_valid |-> tx_size >= 9'h004 && tx_size <= 9'h01A; endproperty
  property p_bad; tx_valid && bad_request |-> tx_size == 9'h004; endproperty
  property p_sec; sec_valid |-> sec_beat == rx_beat && sec_kind == rx_kind && busy; endproperty
  property p_secrdy; sec_valid |-> rx_ready == sec_ready; endproperty
  a_kind: assert property (p_kind) else $error("reply kind wrong");
  a_ans: assert property (p_ans) else $error("reply not started");
  a_hold: assert property (p_hold) else $error("reply byte moved");
  a_first: assert property (p_first) else $error("reply start flag");
  a_end: assert property (p_end) else $error("reply overran");
  a_size: assert property (p_size) else $error("reply size range");
  a_bad: assert property (p_bad) else $error("bad reply size");
  a_sec: assert property (p_sec) else $error("security copy");
  a_secrdy: assert property (p_secrdy) else $error("security stall");
  c_reply: cover property (tx_valid && tx_ready && tx_beat.last);
  c_bad: cover property (tx_valid && bad_request);
  c_sec: cover property (sec_valid && sec_ready && sec_beat.last);
endmodule

bind mir_responder mir_responder_sva mir_responder_sva_inst (.sys_clk, .rst, .rx_valid, .rx_kind, .rx_beat,
  .rx_ready, .tx_valid, .tx_kind, .tx_beat, .tx_size, .tx_ready, .sec_valid, .sec_kind, .sec_beat,
  .sec_ready, .bad_request, .busy);

// ===== verif/manufacturer_info_responder_tb.sv
// self-checking bench for the responder
// assumes a 25 MHz clock, inputs driven at falling edges
`timescale 1ns/1ps

module manufacturer_info_responder_tb;
  logic sys_clk = 0, rst = 1, rx_valid = 0, str_we = 0, slow = 0, sec_ready = 1;
  logic rx_ready, tx_valid, tx_ready, sec_valid, bad_request, busy;
  mir_pkg::mir_msg_e rx_kind = mir_pkg::MIR_MSG_NONE, tx_kind, sec_kind, exp_kind;
  mir_pkg::mir_beat_s rx_beat = '0, tx_beat, sec_beat;
  mir_pkg::mir_beat_s tq[$], sq[$];
  logic [8:0] tx_size, exp_size, batt_present = 9'h1FF;
  logic [3:0] str_src = 4'h0;
  logic [4:0] str_addr = 5'h00;
  logic [7:0] str_wdata = 8'h00, smem[9][22], bq[$];
  logic [15:0] id_v[9], id_p[9];
  logic [8:0] slen[9];
  int num_errors = 0, checks_done = 0, s, a;
  ////////////////////////////////////////////////////////////////
  mir_responder mir_responder_inst (.sys_clk(sys_clk), .rst(rst), .rx_valid(rx_valid), .rx_kind(rx_kind),
    .rx_beat(rx_beat), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_kind(tx_kind), .tx_beat(tx_beat),
    .tx_size(tx_size), .tx_ready(tx_ready), .id_vendor(id_v), .id_product(id_p), .str_len(slen),
    .batt_present(batt_present), .str_we(str_we), .str_src(str_src), .str_addr(str_addr),
    .str_wdata(str_wdata), .sec_valid(sec_valid), .sec_kind(sec_kind), .sec_beat(sec_beat),
    .sec_ready(sec_ready), .bad_request(bad_request), .busy(busy));
  mir_peer mir_peer_inst (.sys_clk(sys_clk), .slow(slow), .tx_ready(tx_ready));
  initial forever #20 sys_clk = ~sys_clk;
  always @(negedge sys_clk) sec_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hold each byte until ready is seen high at an edge
  task automatic send(input mir_pkg::mir_msg_e k);
    int i;
    logic tk;
    rx_valid = 1;
    rx_kind = k;
    for (i = 0; i < bq.size(); ) begin
      rx_beat = '{bq[i], i == 0, i == bq.size() - 1};
      #1 tk = rx_ready;
      @(negedge sys_clk);
      if (tk === 1'b1) i++;
    end
    rx_valid = 0;
    @(negedge sys_clk);
    for (i = 0; i < 300 && busy !== 1'b0; i++) @(negedge sys_clk);
  endtask
  task automatic get(input logic [7:0] tg, input logic [7:0] rf);
    logic ok;
    int n, i;
    logic [7:0] d;
    ok = (tg == 0 && rf == 0) || (tg == 1 && rf < 8 && batt_present[rf[2:0]]);
    n = (tg == 1 && rf < 8) ? int'(rf) : 8; // an absent battery still answers with its own ids
    exp_size = ok ? 9'(4 + (slen[n] > 22 ? 22 : slen[n])) : 9'h004;
    for (i = 0; i < exp_size; i++) begin
      d = i < 2 ? id_v[n][8*i+:8] : i < 4 ? id_p[n][8*(i-2)+:8] : smem[n][i-4];
      tq.push_back('{d, i == 0, i == exp_size - 1});
    end
    bq = '{tg, rf};
    send(mir_pkg::MIR_MSG_GET_INFO);
    chk(16'(tq.size()), 16'h0000); // whole reply seen
    chk(16'(bad_request), 16'(!ok)); // refusal flag
  endtask
  // reply and security byte watcher
  always @(posedge sys_clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      chk(16'(tx_beat), tq.size() ? 16'(tq.pop_front()) : 16'hFFFF); // byte order
      chk(16'(tx_kind), 16'(mir_pkg::MIR_MSG_INFO)); // reply kind
      if (tx_beat.first) chk(16'(tx_size), 16'(exp_size)); // data size
    end
    if (sec_valid === 1'b1 && sec_ready === 1'b1) begin
      chk(16'(sec_beat), sq.size() ? 16'(sq.pop_front()) : 16'hFFFF); // unchanged block
      chk(16'(sec_kind), 16'(exp_kind)); // kind kept
    end
  end
  initial begin
    #400000;
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    summarize();
  end
  initial begin
    void'($urandom(32'h860D2D47));
    batt_present = {1'b1, 8'($urandom)} | 9'h001;
    for (s = 0; s < 9; s++) begin
      id_v[s] = 16'($urandom);
      id_p[s] = 16'($urandom);
      slen[s] = 9'($urandom_range(30));
      for (a = 0; a < 22; a++) smem[s][a] = 8'($urandom);
    end
    slen[0] = 9'h000;
    slen[8] = 9'h005;
    repeat (12) @(negedge sys_clk);
    rst = 0;
    for (s = 0; s < 9; s++) for (a = 0; a < 22; a++) begin
      {str_we, str_src, str_addr, str_wdata} = {1'b1, 4'(s), 5'(a), smem[s][a]};
      @(negedge sys_clk);
    end
    str_we = 0;
    get(8'h00, 8'h00);
    for (s = 0; s < 8; s++) get(8'h01, 8'(s));
    get(8'h02, 8'h00);
    get(8'h00, 8'h03);
    get(8'h01, 8'h08);
    get(8'hFF, 8'h00);
    $display("test info done");
    slow = 1;
    repeat (4) get(8'h01, 8'($urandom_range(7)));
    $display("test stall done");
    for (s = 0; s < 2; s++) begin
      exp_kind = s ? mir_pkg::MIR_MSG_SEC_RSP : mir_pkg::MIR_MSG_SEC_REQ;
      bq = {};
      repeat ($urandom_range(1, 10)) bq.push_back(8'($urandom));
      foreach (bq[a]) sq.push_back('{bq[a], a == 0, a == bq.size() - 1});
      send(exp_kind);
      chk(16'(sq.size()), 16'h0000); // block fully passed
    end
    $display("test security done");
    summarize();
  end
endmodule
